// File: rtl/gse_cfg.svh
// Register offsets, field positions and reset values of the pin event block
`ifndef GSE_CFG_SVH
`define GSE_CFG_SVH
`define GSE_ADDR_W 8
`define GSE_DATA_W 16
`define GSE_OFF_TOP_SHADOW 8'h00
`define GSE_OFF_TOP_STATUS 8'h02
`define GSE_OFF_L2_STATUS 8'h84
`define GSE_OFF_L2_SHADOW 8'hF4
`define GSE_OFF_CTRL 8'h97
`define GSE_OFF_IRQ_CLEAR 8'hA0
`define GSE_OFF_IRQ_ENABLE 8'hA1
`define GSE_NPINS 4
`define GSE_EDGE_POS 4
`define GSE_TOP_PM_BIT 0
`define GSE_CTRL_RESET 8'h00
`define GSE_L2_RESET 4'h0
`define GSE_IEN_RESET 4'h0
`endif

// File: rtl/gse_pkg.sv
// Types shared by the pin event block
package gse_pkg;
    // Pin order in every 4-bit vector: 0 three, 1 four, 2 five, 3 seven
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } gse_req_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] prev;
        logic [7:0] ctrl;
        logic [3:0] l2;
        logic top_pm;
        logic [3:0] ien;
        logic [15:0] rdata;
        logic irq;
        logic irq_n;
    } gse_state_t;
endpackage

// File: rtl/gse_top.sv
// Pin edge event detection, two-level status and management interrupt
// How it works
// - Pin five edge select at bit 6: 0 rising, 1 falling; needs enable bit 2.
// - Pin four edge select at bit 5: 0 rising, 1 falling; needs enable bit 1.
// - Pin three edge select at bit 4: 0 rising, 1 falling; needs enable bit 0.
// - Pin seven enable raises events on its selected edge; disabled raises nothing.
// - Pin five enable raises events on its selected edge; disabled raises nothing.
// - Pin three enable lets its edge raise events; clear blocks them.
// - Pin event sets its second-level bit and top summary bit 0.
// - Interrupt line low while any source pending; released only when all clear.
// - Top status at 02h clears on read; mirror at 00h does not.
// - Second-level status has a mirror and a clear-on-read copy.
// - Both second-level copies read alike; mirror never clears anything.
// - Pin seven edge select at bit 7: 0 rising, 1 falling; needs enable bit 3.
// - Control register at 97h, read-write, eight bits, resets to zero.
`timescale 1ns/1ps
`default_nettype none
`include "gse_cfg.svh"
module gse_top
    import gse_pkg::*;
#(
    parameter int ADDR_W = `GSE_ADDR_W,
    parameter int DATA_W = `GSE_DATA_W
)
(
    input wire logic clk, // 200 MHz core clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] reg_addr, // Register address
    input wire logic [DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic pin_three, // Pin three level
    input wire logic pin_four, // Pin four level
    input wire logic pin_five, // Pin five level
    input wire logic pin_seven, // Pin seven level
    output logic mgmt_irq_n, // Management interrupt, active low
    output logic irq // Level interrupt of enabled status bits
);
    localparam int NP = `GSE_NPINS;

    // Bus decode and packed request are laid out for these widths only
    if (ADDR_W != 8 || DATA_W != 16)
    begin : g_bad_width
        $error("gse_top serves an 8-bit address and 16-bit data only");
    end

    gse_state_t st;
    gse_state_t next_st;
    gse_req_t req;
    logic [NP-1:0] pins;
    logic [NP-1:0] hit;
    logic [NP-1:0] rd_clear;
    logic [NP-1:0] wr_clear;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign pins = {pin_seven, pin_five, pin_four, pin_three};

    // Per-pin edge qualification
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++)
        begin : g_pin
            logic en;
            logic fall_sel;
            assign en = st.ctrl[gi];
            assign fall_sel = st.ctrl[gi + `GSE_EDGE_POS];
            // edge choice honoured only while enabled
            assign hit[gi] = en && (fall_sel ? (st.prev[gi] && !st.s2[gi])
                                             : (!st.prev[gi] && st.s2[gi]));
        end
    endgenerate

    always_comb
    begin
        next_st = st;
        rd_clear = '0;
        wr_clear = '0;
        // two-stage synchroniser; edges seen past the second stage only
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.prev = st.s2;

        if (req.wr && req.addr == `GSE_OFF_CTRL)
            next_st.ctrl = req.wdata[7:0];
        if (req.wr && req.addr == `GSE_OFF_IRQ_ENABLE)
            next_st.ien = req.wdata[NP-1:0];
        if (req.wr && req.addr == `GSE_OFF_IRQ_CLEAR)
            wr_clear = req.wdata[NP-1:0];

        next_st.rdata = '0;
        if (req.rd)
        begin
            case (req.addr)
                // mirror and clearing copy return the same value
                `GSE_OFF_TOP_SHADOW: next_st.rdata[`GSE_TOP_PM_BIT] = st.top_pm;
                `GSE_OFF_TOP_STATUS: next_st.rdata[`GSE_TOP_PM_BIT] = st.top_pm;
                `GSE_OFF_L2_STATUS: next_st.rdata[NP-1:0] = st.l2;
                `GSE_OFF_L2_SHADOW: next_st.rdata[NP-1:0] = st.l2;
                `GSE_OFF_CTRL: next_st.rdata[7:0] = st.ctrl;
                `GSE_OFF_IRQ_ENABLE: next_st.rdata[NP-1:0] = st.ien;
                default: next_st.rdata = '0;
            endcase
        end
        // only the clearing copy clears second-level bits on read; a write to A0h clears them too
        if (req.rd && req.addr == `GSE_OFF_L2_STATUS)
            rd_clear = st.l2;

        // events set both levels; a set in the clearing cycle wins
        next_st.l2 = (st.l2 & ~(rd_clear | wr_clear)) | hit;
        // reading 02h clears the summary; mirror at 00h leaves it
        if (req.rd && req.addr == `GSE_OFF_TOP_STATUS)
            next_st.top_pm = 1'b0;
        if (|hit)
            next_st.top_pm = 1'b1;

        // line held low until every pending source is gone
        next_st.irq_n = !(next_st.top_pm || (|next_st.l2));
        next_st.irq = |(next_st.l2 & next_st.ien);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st <= '0;
            st.ctrl <= `GSE_CTRL_RESET;
            st.l2 <= `GSE_L2_RESET;
            st.ien <= `GSE_IEN_RESET;
            st.irq_n <= 1'b1;
            // Preload with the live level so no false edge follows reset
            st.s1 <= pins;
            st.s2 <= pins;
            st.prev <= pins;
        end
        else
            st <= next_st;
    end

    assign reg_rdata = st.rdata;
    assign mgmt_irq_n = st.irq_n;
    assign irq = st.irq;

    // Checks
    sequence s_rise3;
        st.ctrl[0] && !st.ctrl[4] && !st.prev[0] && st.s2[0];
    endsequence

    sequence s_fall3;
        st.ctrl[0] && st.ctrl[4] && st.prev[0] && !st.s2[0];
    endsequence

    property p_rise_three;
        @(posedge clk) disable iff (srst)
        s_rise3 |=> st.l2[0] && st.top_pm;
    endproperty
    a_rise_three: assert property (p_rise_three) else $error("pin three rise lost");

    property p_fall_three;
        @(posedge clk) disable iff (srst)
        s_fall3 |=> st.l2[0] ##1 !mgmt_irq_n;
    endproperty
    a_fall_three: assert property (p_fall_three) else $error("pin three fall lost");

    property p_four_wrong_edge;
        @(posedge clk) disable iff (srst)
        (st.ctrl[5] && !st.prev[1] && st.s2[1] && !st.l2[1]
         && !(req.wr && req.addr == `GSE_OFF_CTRL)) |=> !st.l2[1];
    endproperty
    a_four_wrong_edge: assert property (p_four_wrong_edge) else $error("pin four wrong edge");

    property p_five_sel;
        @(posedge clk) disable iff (srst)
        (st.ctrl[2] && st.ctrl[6] && st.prev[2] && !st.s2[2]) |=> st.l2[2];
    endproperty
    a_five_sel: assert property (p_five_sel) else $error("pin five fall lost");

    property p_five_off;
        @(posedge clk) disable iff (srst)
        (!st.ctrl[2] && !st.l2[2] && !(req.wr && req.addr == `GSE_OFF_CTRL)) |=> !st.l2[2];
    endproperty
    a_five_off: assert property (p_five_off) else $error("disabled pin five raised");

    property p_seven_edge;
        @(posedge clk) disable iff (srst)
        (st.ctrl[3] && (st.ctrl[7] ? (st.prev[3] && !st.s2[3]) : (!st.prev[3] && st.s2[3])))
        |=> st.l2[3] && st.top_pm;
    endproperty
    a_seven_edge: assert property (p_seven_edge) else $error("pin seven event lost");

    property p_seven_off;
        @(posedge clk) disable iff (srst)
        (!st.ctrl[3] && !st.l2[3] && !(req.wr && req.addr == `GSE_OFF_CTRL)) |=> !st.l2[3];
    endproperty
    a_seven_off: assert property (p_seven_off) else $error("disabled pin seven raised");

    property p_summary;
        @(posedge clk) disable iff (srst)
        (|hit) |=> st.top_pm && ((st.l2 & $past(hit)) == $past(hit));
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit not set");

    property p_line;
        @(posedge clk) disable iff (srst)
        (st.top_pm || (|st.l2)) |-> !mgmt_irq_n;
    endproperty
    a_line: assert property (p_line) else $error("line released while pending");

    property p_top_rc;
        @(posedge clk) disable iff (srst)
        (req.rd && req.addr == `GSE_OFF_TOP_STATUS && st.top_pm && !(|hit))
        |=> !st.top_pm && reg_rdata[0];
    endproperty
    a_top_rc: assert property (p_top_rc) else $error("top status not cleared");

    property p_mirror_keep;
        @(posedge clk) disable iff (srst)
        (req.rd && (req.addr == `GSE_OFF_TOP_SHADOW || req.addr == `GSE_OFF_L2_SHADOW))
        |=> (st.top_pm >= $past(st.top_pm)) && ((st.l2 & $past(st.l2)) == $past(st.l2))
            && reg_rdata != 16'hFFFF;
    endproperty
    a_mirror_keep: assert property (p_mirror_keep) else $error("mirror read cleared");

    property p_l2_rc;
        @(posedge clk) disable iff (srst)
        (req.rd && req.addr == `GSE_OFF_L2_STATUS && !(|hit))
        |=> st.l2 == 4'h0 && reg_rdata[3:0] == $past(st.l2);
    endproperty
    a_l2_rc: assert property (p_l2_rc) else $error("second level not cleared");

    property p_ctrl_rw;
        @(posedge clk) disable iff (srst)
        (req.wr && req.addr == `GSE_OFF_CTRL) ##1 (req.rd && req.addr == `GSE_OFF_CTRL
            && !(req.wr)) |=> reg_rdata[7:0] == $past(req.wdata[7:0], 2);
    endproperty
    a_ctrl_rw: assert property (p_ctrl_rw) else $error("control readback wrong");

    property p_reset_ctrl;
        @(posedge clk) $past(srst) |-> st.ctrl == 8'h00 && mgmt_irq_n;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("control reset not zero");

    sequence s_rise4;
        st.ctrl[1] && !st.ctrl[5] && !st.prev[1] && st.s2[1];
    endsequence

    property p_rise_four;
        @(posedge clk) disable iff (srst)
        s_rise4 |=> st.l2[1] && st.top_pm;
    endproperty
    a_rise_four: assert property (p_rise_four) else $error("pin four rise lost");

    property p_fall_four;
        @(posedge clk) disable iff (srst)
        (st.ctrl[1] && st.ctrl[5] && st.prev[1] && !st.s2[1]) |=> st.l2[1] && st.top_pm;
    endproperty
    a_fall_four: assert property (p_fall_four) else $error("pin four fall lost");

    property p_five_rise;
        @(posedge clk) disable iff (srst)
        (st.ctrl[2] && !st.ctrl[6] && !st.prev[2] && st.s2[2]) |=> st.l2[2] && st.top_pm;
    endproperty
    a_five_rise: assert property (p_five_rise) else $error("pin five rise lost");

    property p_three_off;
        @(posedge clk) disable iff (srst)
        (!st.ctrl[0] && !st.l2[0] && !(req.wr && req.addr == `GSE_OFF_CTRL)) |=> !st.l2[0];
    endproperty
    a_three_off: assert property (p_three_off) else $error("disabled pin three raised");

    property p_release;
        @(posedge clk) disable iff (srst)
        (!st.top_pm && st.l2 == 4'h0) |-> mgmt_irq_n;
    endproperty
    a_release: assert property (p_release) else $error("line held with nothing pending");

    property p_top_mirror;
        @(posedge clk) disable iff (srst)
        (req.rd && req.addr == `GSE_OFF_TOP_SHADOW) |=> reg_rdata == {15'h0000, $past(st.top_pm)};
    endproperty
    a_top_mirror: assert property (p_top_mirror) else $error("top mirror data wrong");

    property p_l2_mirror;
        @(posedge clk) disable iff (srst)
        (req.rd && req.addr == `GSE_OFF_L2_SHADOW) |=> reg_rdata == {12'h000, $past(st.l2)};
    endproperty
    a_l2_mirror: assert property (p_l2_mirror) else $error("second level mirror wrong");

    property p_clear_write;
        @(posedge clk) disable iff (srst)
        (req.wr && req.addr == `GSE_OFF_IRQ_CLEAR && !(|hit))
        |=> (st.l2 & $past(req.wdata[3:0])) == 4'h0;
    endproperty
    a_clear_write: assert property (p_clear_write) else $error("clear write ignored");

    property p_sync;
        @(posedge clk) disable iff (srst)
        !$past(srst) |-> st.s1 == $past(pins) && st.s2 == $past(st.s1);
    endproperty
    a_sync: assert property (p_sync) else $error("synchroniser skipped a stage");

    genvar ai;
    generate
        for (ai = 0; ai < NP; ai++)
        begin : g_once
            property p_once;
                @(posedge clk) disable iff (srst)
                hit[ai] |=> !hit[ai];
            endproperty
            a_once: assert property (p_once) else $error("edge counted twice");
        end
    endgenerate
endmodule
`default_nettype wire

// File: sim/gse_host_model.sv
// Host side model counting management interrupt assertions
`timescale 1ns/1ps
`default_nettype none
module gse_host_model
(
    input wire logic clk, // Core clock
    input wire logic srst, // Synchronous reset
    input wire logic mgmt_irq_n, // Interrupt from block, active low
    output logic [7:0] n_taken // Assertions seen
);
    logic last_n;
    always_ff @(posedge clk)
    begin
        last_n <= srst ? 1'b1 : mgmt_irq_n;
        if (srst)
            n_taken <= 8'h00;
        else if (last_n && !mgmt_irq_n)
            n_taken <= n_taken + 8'h01;
    end
endmodule
`default_nettype wire

// File: sim/tb_gse_top.sv
// Self-checking bench of the pin event block
`timescale 1ns/1ps
`default_nettype none
module tb_gse_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [3:0] pins = 4'h0;
    logic mgmt_irq_n;
    logic irq;
    logic [7:0] n_taken;
    logic rd_d = 1'b0;
    logic [15:0] d;
    logic [15:0] expq[$];
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int e;
    int pn;
    always #2.5 clk = ~clk;
    gse_top DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_three(pins[0]),
        .pin_four(pins[1]), .pin_five(pins[2]), .pin_seven(pins[3]),
        .mgmt_irq_n(mgmt_irq_n), .irq(irq));
    gse_host_model HOST (.clk(clk), .srst(srst), .mgmt_irq_n(mgmt_irq_n), .n_taken(n_taken));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        expq.push_back(v);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    // Expected data queued at issue, compared when it stands
    task automatic rd(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        expq.push_back(v);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    // Two extra edges let registered outputs settle
    task automatic line(input logic m, input logic q);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({14'h0000, mgmt_irq_n, irq}, {14'h0000, m, q});
    endtask
    // Four edges cover the synchroniser and status update
    task automatic pin(input int i, input logic v);
        // pins only ever driven into the block
        @(posedge clk);
        pins[i] <= v;
        repeat (4) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        if (rd_d)
            chk(reg_rdata, expq.pop_front());
        rd_d <= reg_rd;
        cycles++;
        if (cycles == 6000)
        begin
            n_errors++;
            end_sim();
        end
    end
    initial
    begin
        void'($urandom(32'h5532b79d));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(8'h97, 16'h0000);
        e = $urandom;
        wr_rd(8'h97, {8'h00, e[7:0]});
        rd(8'h10, 16'h0000);
        wr(8'h97, 16'h0000);
        wr(8'hA1, 16'h000F);
        // Every pin once with each edge select
        for (int k = 0; k < 8; k++)
        begin
            pn = k % 4;
            e = k / 4;
            // The selected edge once while disabled
            pin(pn, e[0]);
            pin(pn, !e[0]);
            rd(8'hF4, 16'h0000);
            d = (16'h0001 << pn) | ({15'h0000, e[0]} << (4 + pn));
            wr(8'h97, d);
            // Wrong edge first, then the selected one
            pin(pn, e[0]);
            rd(8'hF4, 16'h0000);
            pin(pn, !e[0]);
            rd(8'hF4, 16'h0001 << pn);
            rd(8'hF4, 16'h0001 << pn);
            rd(8'h00, 16'h0001);
            rd(8'h02, 16'h0001);
            rd(8'h02, 16'h0000);
            line(1'b0, 1'b1);
            wr(8'hA1, 16'h0000);
            line(1'b0, 1'b0);
            wr(8'hA1, 16'h000F);
            line(1'b0, 1'b1);
            if ((pn + k / 4) % 2 == 1)
                wr(8'hA0, 16'h0001 << pn);
            else
                rd(8'h84, 16'h0001 << pn);
            line(1'b1, 1'b0);
            rd(8'hF4, 16'h0000);
        end
        // Let the last read data be compared
        repeat (2) @(posedge clk);
        chk({8'h00, n_taken}, 16'h0008);
        // Reset in mid-run while every pin goes high
        @(posedge clk);
        srst <= 1'b1;
        pins <= 4'hF;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        wr(8'h97, 16'h000F);
        line(1'b1, 1'b0);
        rd(8'hF4, 16'h0000);
        rd(8'h02, 16'h0000);
        repeat (2) @(posedge clk);
        chk({8'h00, n_taken}, 16'h0000);
        end_sim();
    end
endmodule
`default_nettype wire
